// ### shared/usbsc_pkg.sv
// Purpose: constants and types shared by the usb setup/power control block
// Assumes: 40 MHz core clock, 32-bit apb data, byte addresses
// Notes:   offsets are byte addresses of aligned words
package usbsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SETUP_CLR = 8'h08;
    localparam logic [7:0] OFS_PWRCTL = 8'h0c;
    localparam logic [7:0] OFS_KEY = 8'h10;
    localparam logic [7:0] OFS_BAD_KEY = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h20;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_MOD_EN = 0;
    localparam int CTRL_BUS_EN = 1;
    localparam int ST_SETUP = 0;
    localparam int ST_VBUS = 1;
    localparam int ST_LOCKED = 2;
    localparam int ST_ACCV = 3;
    localparam int ST_TX = 4;
    localparam int ST_DET_ERR = 5;
    localparam int PWR_W = 8;
    localparam int PWR_LDO = 0;
    localparam int KEY_W = 16;
    localparam int IRQ_W = 3;
    localparam int IRQ_SETUP = 0;
    localparam int IRQ_ACCV = 1;
    localparam int IRQ_VBUS = 2;

    // ------------------------------------------------------------
    // reset values and key values
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [PWR_W-1:0] PWR_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
    localparam logic [KEY_W-1:0] LOCK_KEY = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 25;
    localparam int T_HAZ_NS = 83;
    localparam int GUARD_CYC = (T_HAZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int TX_LEN_CYC = 64;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        USBSC_PID_SETUP = 2'h0,
        USBSC_PID_IN = 2'h1,
        USBSC_PID_OUT = 2'h2,
        USBSC_PID_OTHER = 2'h3
    } usbsc_pid_t;

    typedef enum logic [1:0] {
        USBSC_HS_NONE = 2'h0,
        USBSC_HS_ACK = 2'h1,
        USBSC_HS_NAK = 2'h2,
        USBSC_HS_DATA = 2'h3
    } usbsc_hs_t;

endpackage

// ### shared/usbsc_if.sv
// Purpose: carriers between the top module and its two helpers
// Assumes: all signals on core_clk_i
// Notes:   reg_if carries decoded bus accesses, hs_if the token engine
`timescale 1ns/1ps

interface usbsc_reg_if;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic [31:0] rdata;
    logic err;
    modport slv (output addr, output wdata, output wr_stb, input rdata, input err);
    modport core (input addr, input wdata, input wr_stb, output rdata, output err);
endinterface

interface usbsc_hs_if;
    logic soft_rst;
    logic bus_en;
    logic setup_flag;
    logic tok_valid;
    usbsc_pkg::usbsc_pid_t tok_pid;
    logic setup_seen;
    logic hs_valid;
    usbsc_pkg::usbsc_hs_t hs_code;
    logic tx_busy;
    modport eng (input soft_rst, input bus_en, input setup_flag, input tok_valid,
                 input tok_pid, output setup_seen, output hs_valid, output hs_code,
                 output tx_busy);
    modport core (output soft_rst, output bus_en, output setup_flag, output tok_valid,
                  output tok_pid, input setup_seen, input hs_valid, input hs_code,
                  input tx_busy);
endinterface

// ### hdl/usbsc_apb_slave.sv
// Purpose: apb slave front end with one wait state
// Assumes: master holds the request until pready
// Notes:   pready, prdata and pslverr come from flip-flops
`timescale 1ns/1ps

module usbsc_apb_slave (
    input wire logic core_clk_i,    // core clock
    input wire logic rst_i,         // sync reset, active high
    input wire logic psel_i,        // apb select
    input wire logic penable_i,     // apb enable
    input wire logic pwrite_i,      // apb direction
    input wire logic [7:0] paddr_i, // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o,   // apb read data
    output logic pready_o,          // apb ready
    output logic pslverr_o,         // apb error
    usbsc_reg_if.slv bus            // decoded access
);
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    wire access_w = psel_i & penable_i;
    wire first_w = access_w & ~pready_r;

    assign bus.addr = paddr_i;
    assign bus.wdata = pwdata_i;
    // write takes effect only at the edge where pready is seen high
    assign bus.wr_stb = access_w & pready_r & pwrite_i & ~pslverr_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= first_w;
            pslverr_r <= first_w & bus.err;
            if (first_w) begin
                prdata_r <= pwrite_i ? 32'h0000_0000 : bus.rdata;
            end
        end
    end

    a_ready_one_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (psel_i && penable_i && !pready_r) |=> pready_r)
        else $error("apb ready not given one cycle into access");
endmodule

// ### hdl/usbsc_tok_engine.sv
// Purpose: answers host tokens with a handshake or a bounded data phase
// Assumes: tokens arrive already decoded, on the core clock
// Notes:   the data phase ends by a length count, so it cannot run on
`timescale 1ns/1ps

module usbsc_tok_engine #(
    parameter int TX_LEN = usbsc_pkg::TX_LEN_CYC // data phase length in cycles
) (
    input wire logic core_clk_i,    // core clock
    input wire logic rst_i,         // sync reset, active high
    usbsc_hs_if.eng hs              // token and handshake carrier
);
    typedef enum logic [1:0] {USBSC_E_IDLE, USBSC_E_TX} usbsc_eng_t;
    usbsc_eng_t state_r;
    logic [$clog2(TX_LEN+1)-1:0] cnt_r;
    logic hs_valid_r;
    logic setup_seen_r;
    logic tx_busy_r;
    usbsc_pkg::usbsc_hs_t code_r;
    wire take_w = hs.tok_valid & hs.bus_en & (state_r == USBSC_E_IDLE);
    wire is_setup_w = take_w & (hs.tok_pid == usbsc_pkg::USBSC_PID_SETUP);
    wire is_in_w = take_w & (hs.tok_pid == usbsc_pkg::USBSC_PID_IN);
    wire is_out_w = take_w & (hs.tok_pid == usbsc_pkg::USBSC_PID_OUT);

    assign hs.hs_valid = hs_valid_r;
    assign hs.hs_code = code_r;
    assign hs.setup_seen = setup_seen_r;
    assign hs.tx_busy = tx_busy_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || hs.soft_rst) begin
            state_r <= USBSC_E_IDLE;
            cnt_r <= '0;
            hs_valid_r <= 1'b0;
            setup_seen_r <= 1'b0;
            tx_busy_r <= 1'b0;
            code_r <= usbsc_pkg::USBSC_HS_NONE;
        end else begin
            hs_valid_r <= is_setup_w | is_in_w | is_out_w;
            setup_seen_r <= is_setup_w;
            case (state_r)
                USBSC_E_IDLE: begin
                    if (is_in_w && hs.setup_flag) begin
                        code_r <= usbsc_pkg::USBSC_HS_NAK;
                    end else if (is_in_w) begin
                        code_r <= usbsc_pkg::USBSC_HS_DATA;
                        cnt_r <= TX_LEN[$bits(cnt_r)-1:0];
                        state_r <= USBSC_E_TX;
                        tx_busy_r <= 1'b1;
                    end else if (is_setup_w || is_out_w) begin
                        code_r <= usbsc_pkg::USBSC_HS_ACK;
                    end else begin
                        code_r <= usbsc_pkg::USBSC_HS_NONE;
                    end
                end
                USBSC_E_TX: begin
                    code_r <= usbsc_pkg::USBSC_HS_NONE;
                    cnt_r <= cnt_r - 1'b1;
                    if (cnt_r <= 1) begin
                        state_r <= USBSC_E_IDLE;
                        tx_busy_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= USBSC_E_IDLE;
                    tx_busy_r <= 1'b0;
                end
            endcase
        end
    end

    a_nak_while_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (is_in_w && hs.setup_flag && !hs.soft_rst) |=>
        (hs_valid_r && code_r == usbsc_pkg::USBSC_HS_NAK))
        else $error("in token not refused while setup flag high");
    a_tx_bounded: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (state_r == USBSC_E_TX) |-> (cnt_r <= TX_LEN))
        else $error("data phase counter out of range");
endmodule

// ### hdl/usbsc_top.sv
// Purpose: usb function-side setup tracking, power control and register lock
// Assumes: tokens decoded upstream on core_clk_i; vbus and fault from pins
// Notes:   registers over apb with one wait state
`timescale 1ns/1ps

module usbsc_top #(
    parameter logic [15:0] UNLOCK_KEY = 16'h5a3c, // arbitrary unlock value
    parameter int TX_LEN = usbsc_pkg::TX_LEN_CYC  // data phase length
) (
    input wire logic core_clk_i,      // core clock, 40 mhz
    input wire logic rst_i,           // sync reset, active high
    input wire logic psel_i,          // apb select
    input wire logic penable_i,       // apb enable
    input wire logic pwrite_i,        // apb direction
    input wire logic [7:0] paddr_i,   // apb byte address
    input wire logic [31:0] pwdata_i, // apb write data
    output logic [31:0] prdata_o,     // apb read data
    output logic pready_o,            // apb ready
    output logic pslverr_o,           // apb error
    input wire logic tok_valid_i,     // decoded token strobe
    input wire logic [1:0] tok_pid_i, // decoded token type
    input wire logic in_busy_i,       // in token still arriving
    input wire logic vbus_i,          // vbus comparator pin
    input wire logic bg_fault_i,      // bandgap detector fault pin
    output logic hs_valid_o,          // handshake strobe
    output logic [1:0] hs_code_o,     // handshake code
    output logic tx_busy_o,           // data phase running
    output logic ldo_en_o,            // regulator enable
    output logic acc_viol_o,          // access violation flag
    output logic irq_o                // interrupt, level
);
    // ------------------------------------------------------------
    // carriers and helpers
    // ------------------------------------------------------------
    usbsc_reg_if rbus();
    usbsc_hs_if hsb();

    usbsc_apb_slave u_apb (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .bus(rbus.slv)
    );

    usbsc_tok_engine #(.TX_LEN(TX_LEN)) u_eng (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .hs(hsb.eng)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [1:0] ctrl_r;
    logic mod_en_d_r;
    logic setup_flag_r;
    logic clr_pend_r;
    logic [2:0] quiet_r;
    logic [usbsc_pkg::PWR_W-1:0] pwr_r;
    logic det_err_r;
    logic locked_r;
    logic accv_r;
    logic ldo_en_r;
    logic [usbsc_pkg::IRQ_W-1:0] irq_st_r;
    logic [usbsc_pkg::IRQ_W-1:0] irq_en_r;
    logic irq_r;
    logic [2:0] vbus_s_r;
    logic [2:0] flt_s_r;
    logic vbus_r;
    logic flt_r;
    logic vbus_prev_r;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire wr_w = rbus.wr_stb;
    wire [7:0] a_w = rbus.addr;
    wire [31:0] wd_w = rbus.wdata;
    wire sel_ctrl_w = hit(a_w, usbsc_pkg::OFS_CTRL);
    wire sel_stat_w = hit(a_w, usbsc_pkg::OFS_STAT);
    wire sel_sclr_w = hit(a_w, usbsc_pkg::OFS_SETUP_CLR);
    wire sel_pwr_w = hit(a_w, usbsc_pkg::OFS_PWRCTL);
    wire sel_key_w = hit(a_w, usbsc_pkg::OFS_KEY);
    wire sel_bad_w = hit(a_w, usbsc_pkg::OFS_BAD_KEY);
    wire sel_ist_w = hit(a_w, usbsc_pkg::OFS_IRQ_STAT);
    wire sel_icl_w = hit(a_w, usbsc_pkg::OFS_IRQ_CLR);
    wire sel_ien_w = hit(a_w, usbsc_pkg::OFS_IRQ_EN);
    wire mapped_w = sel_ctrl_w | sel_stat_w | sel_sclr_w | sel_pwr_w | sel_key_w
                  | sel_bad_w | sel_ist_w | sel_icl_w | sel_ien_w;
    wire guarded_w = sel_ctrl_w | sel_sclr_w | sel_pwr_w;

    // locked registers refuse writes; the bad key alias answers as an error
    assign rbus.err = ~mapped_w | sel_bad_w | (pwrite_i & locked_r & guarded_w);

    wire wr_ctrl_w = wr_w & sel_ctrl_w;
    wire wr_sclr_w = wr_w & sel_sclr_w & wd_w[0];
    wire wr_pwr_w = wr_w & sel_pwr_w;
    wire wr_key_w = wr_w & sel_key_w;
    wire wr_icl_w = wr_w & sel_icl_w;
    wire wr_ien_w = wr_w & sel_ien_w;
    // the bad key address is refused by the slave, so catch its write access directly
    wire bad_key_w = psel_i & penable_i & pwrite_i & ~pready_o & sel_bad_w;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] stat_w = {26'h0, det_err_r, tx_busy_o, accv_r, locked_r,
                          vbus_r & ~det_err_r, setup_flag_r};
    assign rbus.rdata = sel_ctrl_w ? {30'h0, ctrl_r} :
                        sel_stat_w ? stat_w :
                        sel_pwr_w ? {24'h0, pwr_r} :
                        sel_ist_w ? {29'h0, irq_st_r} :
                        sel_ien_w ? {29'h0, irq_en_r} : 32'h0000_0000;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            vbus_s_r <= 3'h0;
            flt_s_r <= 3'h0;
            vbus_r <= 1'b0;
            flt_r <= 1'b0;
        end else begin
            vbus_s_r <= {vbus_s_r[1:0], vbus_i};
            flt_s_r <= {flt_s_r[1:0], bg_fault_i};
            if (vbus_s_r[1] == vbus_s_r[2]) begin
                vbus_r <= vbus_s_r[2];
            end
            if (flt_s_r[1] == flt_s_r[2]) begin
                flt_r <= flt_s_r[2];
            end
        end
    end

    // ------------------------------------------------------------
    // control, module reset and token carrier
    // ------------------------------------------------------------
    wire mod_en_w = ctrl_r[usbsc_pkg::CTRL_MOD_EN];
    wire soft_rst_w = ~mod_en_w;
    wire mod_restart_w = mod_en_w & ~mod_en_d_r;

    assign hsb.soft_rst = soft_rst_w;
    assign hsb.bus_en = ctrl_r[usbsc_pkg::CTRL_BUS_EN];
    assign hsb.setup_flag = setup_flag_r;
    assign hsb.tok_valid = tok_valid_i;
    assign hsb.tok_pid = usbsc_pkg::usbsc_pid_t'(tok_pid_i);
    assign hs_valid_o = hsb.hs_valid;
    assign hs_code_o = hsb.hs_code;
    assign tx_busy_o = hsb.tx_busy;

    // a clear may only land once the in token has been quiet for the hazard span
    wire quiet_w = (quiet_r >= 3'(usbsc_pkg::GUARD_CYC));
    wire do_clr_w = (clr_pend_r | wr_sclr_w) & quiet_w & ~in_busy_i;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_r <= usbsc_pkg::CTRL_RST;
            mod_en_d_r <= 1'b0;
            quiet_r <= 3'h0;
        end else begin
            mod_en_d_r <= mod_en_w;
            if (wr_ctrl_w) begin
                ctrl_r <= wd_w[1:0];
            end
            if (in_busy_i) begin
                quiet_r <= 3'h0;
            end else if (!quiet_w) begin
                quiet_r <= quiet_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // setup flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i || soft_rst_w) begin
            setup_flag_r <= 1'b0;
            clr_pend_r <= 1'b0;
        end else if (hsb.setup_seen) begin
            setup_flag_r <= 1'b1;
            clr_pend_r <= 1'b0;
        end else if (do_clr_w) begin
            setup_flag_r <= 1'b0;
            clr_pend_r <= 1'b0;
        end else if (wr_sclr_w) begin
            clr_pend_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power control and detector error
    // ------------------------------------------------------------
    wire pwr_zero_w = wr_pwr_w & (wd_w[usbsc_pkg::PWR_W-1:0] == usbsc_pkg::PWR_RST);

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pwr_r <= usbsc_pkg::PWR_RST;
            det_err_r <= 1'b0;
            ldo_en_r <= 1'b0;
        end else begin
            if (wr_pwr_w) begin
                pwr_r <= wd_w[usbsc_pkg::PWR_W-1:0];
            end
            if (flt_r) begin
                det_err_r <= 1'b1;
            end else if (pwr_zero_w) begin
                det_err_r <= 1'b0;
            end
            ldo_en_r <= pwr_r[usbsc_pkg::PWR_LDO] & ~det_err_r & ~pwr_zero_w;
        end
    end
    assign ldo_en_o = ldo_en_r;

    // ------------------------------------------------------------
    // register lock and access violation
    // ------------------------------------------------------------
    wire [15:0] key_w = wd_w[usbsc_pkg::KEY_W-1:0];

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            locked_r <= 1'b0;
            accv_r <= 1'b0;
        end else begin
            if (wr_key_w && key_w == usbsc_pkg::LOCK_KEY) begin
                locked_r <= 1'b1;
            end else if (wr_key_w && key_w == UNLOCK_KEY) begin
                locked_r <= 1'b0;
            end
            if (bad_key_w) begin
                accv_r <= 1'b1;
            end else if (wr_icl_w && wd_w[usbsc_pkg::IRQ_ACCV]) begin
                accv_r <= 1'b0;
            end
        end
    end
    assign acc_viol_o = accv_r;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [usbsc_pkg::IRQ_W-1:0] ev_w = {vbus_r ^ vbus_prev_r, bad_key_w, hsb.setup_seen};

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_st_r <= '0;
            irq_en_r <= usbsc_pkg::IRQ_EN_RST;
            irq_r <= 1'b0;
            vbus_prev_r <= 1'b0;
        end else begin
            vbus_prev_r <= vbus_r;
            // a new event wins over a clear in the same cycle
            irq_st_r <= (irq_st_r & ~(wr_icl_w ? wd_w[usbsc_pkg::IRQ_W-1:0] : '0)) | ev_w;
            if (wr_ien_w) begin
                irq_en_r <= wd_w[usbsc_pkg::IRQ_W-1:0];
            end
            irq_r <= |(irq_st_r & irq_en_r);
        end
    end
    assign irq_o = irq_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_setup_sets_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (hsb.setup_seen && !soft_rst_w) |=> (setup_flag_r && irq_st_r[0]))
        else $error("setup did not set flag and status");
    a_clear_in_window: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (in_busy_i && setup_flag_r && !soft_rst_w && !hsb.setup_seen) |=> setup_flag_r)
        else $error("setup flag cleared during in token");
    a_tx_ends: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(tx_busy_o) |-> ##[1:300] !tx_busy_o)
        else $error("transmit did not end");
    a_modreset_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
        soft_rst_w |=> (!setup_flag_r && !tx_busy_o))
        else $error("module reset left link state");
    a_vbus_status: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (vbus_s_r[2] && vbus_s_r[1] && !det_err_r && !flt_r) |=> stat_w[1])
        else $error("vbus status not reported");
    a_pwr_zero_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (pwr_zero_w && !flt_r) |=> (!det_err_r && !ldo_en_o))
        else $error("zero power write did not clear error");
    a_key_locks: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (wr_key_w && key_w == 16'h0000) |=> locked_r)
        else $error("zero key did not lock");
    a_bad_key: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (bad_key_w && !locked_r) |=> (accv_r && !locked_r))
        else $error("bad key address handled wrongly");
    a_irq_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ##1 (irq_o == $past(|(irq_st_r & irq_en_r))))
        else $error("interrupt output wrong");
    a_bus_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!ctrl_r[1] && !tx_busy_o) |=> !hs_valid_o)
        else $error("token answered with bus disabled");
endmodule

// ### testbench/usbsc_host_model.sv
// Purpose: host side token source for the bench
// Assumes: one token per send pulse, core clock
// Notes:   idle token type toggles so a stale value never looks valid
`timescale 1ns/1ps
module usbsc_host_model (
    input wire logic core_clk_i, // core clock
    input wire logic send_i, // issue a token
    input wire logic [1:0] pid_i, // token type
    output logic tok_valid_o = 0, // token strobe
    output logic [1:0] tok_pid_o = 0, // token type
    output logic in_busy_o = 0 // in token arriving
);
    always @(posedge core_clk_i) begin
        tok_valid_o <= send_i;
        tok_pid_o <= send_i ? pid_i : ~tok_pid_o;
        in_busy_o <= send_i && pid_i == 2'h1;
    end
endmodule

// ### testbench/tb_usb_setup_and_power_control.sv
// Purpose: self-checking bench for usbsc_top
// Assumes: apb master waits for pready, host model feeds tokens
// Notes:   data phase cut to 4 cycles
`timescale 1ns/1ps
module tb_usb_setup_and_power_control;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0, vbus = 0, flt = 0;
    logic [7:0] pa = 0;
    logic [31:0] pw = 0, rd, prd, lf = 32'h9a4a;
    logic [1:0] pid = 0, tp, hc;
    logic tv, ib, hv, txb, ldo, acv, irq, prdy, perr;
    int errors = 0, num_checks = 0;
    usbsc_top #(.UNLOCK_KEY(16'h1234), .TX_LEN(4)) i_dut (.core_clk_i(clk), .rst_i(rst),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pw),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .tok_valid_i(tv), .tok_pid_i(tp),
        .in_busy_i(ib), .vbus_i(vbus), .bg_fault_i(flt), .hs_valid_o(hv), .hs_code_o(hc),
        .tx_busy_o(txb), .ldo_en_o(ldo), .acc_viol_o(acv), .irq_o(irq));
    usbsc_host_model i_host (.core_clk_i(clk), .send_i(send), .pid_i(pid), .tok_valid_o(tv),
        .tok_pid_o(tp), .in_busy_o(ib));
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic er);
        int i;
        @(posedge clk);
        {psel, pwr, pa, pw} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1;
        for (i = 0; prdy !== 1'b1; i++)
            @(posedge clk);
        rd = prd;
        chk("rdy", i, 2);
        chk("err", perr, er);
        {psel, pen} <= 2'b0;
    endtask
    task automatic st(logic [8:0] e);
        apb(0, usbsc_pkg::OFS_STAT, 0, 0);
        chk("stat", {rd[7:0], ldo}, e);
    endtask
    task automatic tok(logic [1:0] p, logic [2:0] e);
        {send, pid} <= {1'b1, p};
        @(posedge clk);
        send <= 0;
        @(posedge clk);
        #1 chk("hs", {hv, hc}, e);
    endtask
    task finish_test;
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        st(9'h000);
        apb(0, 8'h24, 0, 1);
        tok(2'h0, 3'h0);
        apb(1, usbsc_pkg::OFS_CTRL, 3, 0);
        apb(1, usbsc_pkg::OFS_IRQ_EN, 7, 0);
        tok(2'h0, 3'h5);
        repeat (2) @(posedge clk);
        #1 chk("irq", irq, 1);
        tok(2'h1, 3'h6);
        tok(2'h1, 3'h6);
        apb(1, usbsc_pkg::OFS_SETUP_CLR, 1, 0);
        repeat (6) @(posedge clk);
        tok(2'h1, 3'h7);
        repeat (3) @(posedge clk);
        #1 chk("txb", txb, 1);
        @(posedge clk);
        #1 chk("txb", txb, 0);
        apb(0, usbsc_pkg::OFS_IRQ_STAT, 0, 0);
        chk("irqst", rd, 1);
        apb(1, usbsc_pkg::OFS_IRQ_CLR, 1, 0);
        apb(1, usbsc_pkg::OFS_IRQ_EN, 5, 0);
        apb(1, usbsc_pkg::OFS_BAD_KEY, 0, 1);
        st(9'h010);
        chk("acv", {acv, irq}, 2'b10);
        apb(1, usbsc_pkg::OFS_KEY, 0, 0);
        st(9'h018);
        apb(1, usbsc_pkg::OFS_CTRL, 0, 1);
        apb(1, usbsc_pkg::OFS_KEY, 32'h1234, 0);
        apb(1, usbsc_pkg::OFS_IRQ_CLR, 2, 0);
        vbus <= 1;
        lf = nxt(lf);
        apb(1, usbsc_pkg::OFS_PWRCTL, lf[7:0] | 8'h01, 0);
        repeat (5) @(posedge clk);
        st(9'h005);
        flt <= 1;
        repeat (5) @(posedge clk);
        st(9'h040);
        flt <= 0;
        repeat (4) @(posedge clk);
        apb(1, usbsc_pkg::OFS_PWRCTL, 0, 0);
        apb(1, usbsc_pkg::OFS_PWRCTL, 1, 0);
        st(9'h005);
        tok(2'h0, 3'h5);
        apb(1, usbsc_pkg::OFS_CTRL, 1, 0);
        tok(2'h1, 3'h0);
        apb(1, usbsc_pkg::OFS_SETUP_CLR, 1, 0);
        apb(1, usbsc_pkg::OFS_CTRL, 3, 0);
        st(9'h005);
        tok(2'h0, 3'h5);
        apb(1, usbsc_pkg::OFS_CTRL, 0, 0);
        apb(1, usbsc_pkg::OFS_CTRL, 3, 0);
        st(9'h005);
        tok(2'h1, 3'h7);
        finish_test();
    end
endmodule
